// ===== design/lvd_ctrl.sv
// Supply drop detector control, flag, wake and Avalon-MM register slave
//
// Operation
// - Control bits 7-6 absent, read zero
// - Bit 5 reads reference-stable state, read-only
// - Bit 4 powers and enables the detector
// - Bits 3-0 hold trip code; 0000 reserved
// - Code 1111 selects external trip input
// - Comparator ignored until stabilisation completes
// - Low flag inactive until reference stable
// - Settling time timed independently of core clock
// - Supply drop sets low flag, even asleep
// - Flag in sleep raises wake request
// - Vector after wake only with global enable
// - Cleared flag re-sets while condition persists
// - Reset returns all bits, detector off
// - External mode compares pin against reference
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`default_nettype none
module lvd_ctrl (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ref_osc_clk,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cmp_below,
  output logic detector_power_enable,
  output logic [3:0] trip_level_code,
  output logic ext_input_select,
  output logic irq,
  output logic wake_req,
  output logic vector_req
);
  logic settled_raw;
  logic reference_stable_flag;
  logic below_sync;
  logic low_voltage_flag_q;
  logic stable_evt_q;
  logic [1:0] mask_q;
  logic global_irq_enable_q;
  logic sleep_q;
  logic low_voltage_irq_enable;
  logic stable_prev_q;
  logic bus_req;
  logic accept;
  logic settled_sync;
  logic timer_en_q;
  logic wr_hit;
  logic drop_event;
  logic [31:0] rdata_d;

  // Reference settling runs on its own oscillator
  lvd_settle_timer u_settle (
    .ref_osc_clk(ref_osc_clk),
    .ref_reset(reset),
    .power_en(timer_en_q),
    .settled(settled_raw)
  );

  // Both analog-side levels crossed before use
  lvd_sync u_sync_stable (
    .core_clk(core_clk),
    .reset(reset),
    .async_in(settled_raw),
    .sync_out(settled_sync)
  );

  // Timer enable falls with the detector and rises again only after the
  // old settled level has been seen low, so a quick off-on still waits
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      timer_en_q <= 1'b0;
    end else begin
      timer_en_q <= detector_power_enable && (timer_en_q || !settled_sync);
    end
  end
  // Stable only while powered and timing the current enable
  assign reference_stable_flag = settled_sync && timer_en_q
                                 && detector_power_enable;
  lvd_sync u_sync_cmp (
    .core_clk(core_clk),
    .reset(reset),
    .async_in(cmp_below),
    .sync_out(below_sync)
  );

  // One wait state; waitrequest is a flop, so it never glitches
  assign bus_req = avs_read || avs_write;
  assign accept = bus_req && !avs_waitrequest;
  assign wr_hit = avs_write && accept && avs_byteenable[0];
  // Writes land only on the edge where waitrequest is seen low
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
    end
  end

  // Control bits; only low byte lane carries them
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      detector_power_enable <= lvd_pkg::EN_RESET;
      trip_level_code <= lvd_pkg::LEVEL_RESET;
    end else if (wr_hit && avs_address == lvd_pkg::ADDR_CTRL) begin
      detector_power_enable <= avs_writedata[lvd_pkg::CTRL_EN_BIT];
      trip_level_code <= avs_writedata[lvd_pkg::CTRL_LEVEL_MSB:0];
    end
  end

  // Tap mux steering; registered so it comes from a flop
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ext_input_select <= 1'b0;
    end else begin
      ext_input_select <= (trip_level_code == lvd_pkg::LEVEL_EXTERNAL);
    end
  end

  // Mask and system bits
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mask_q <= 2'h0;
      global_irq_enable_q <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      if (wr_hit && avs_address == lvd_pkg::ADDR_MASK) begin
        mask_q <= avs_writedata[1:0];
      end
      if (wr_hit && avs_address == lvd_pkg::ADDR_SYS) begin
        global_irq_enable_q <= avs_writedata[lvd_pkg::SYS_GIE_BIT];
        sleep_q <= avs_writedata[lvd_pkg::SYS_SLEEP_BIT];
      end else if (wake_req) begin
        sleep_q <= 1'b0;
      end
    end
  end
  assign low_voltage_irq_enable = mask_q[lvd_pkg::STAT_LOW_BIT];

  // Drop counts only when enabled and reference settled; works in sleep too
  assign drop_event = detector_power_enable && reference_stable_flag && below_sync;

  // Sticky flags, write one to clear; set beats clear so a held drop re-sets
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      low_voltage_flag_q <= 1'b0;
      stable_evt_q <= 1'b0;
      stable_prev_q <= 1'b0;
    end else begin
      stable_prev_q <= reference_stable_flag;
      if (drop_event) begin
        low_voltage_flag_q <= 1'b1;
      end else if (wr_hit && avs_address == lvd_pkg::ADDR_STATUS
                   && avs_writedata[lvd_pkg::STAT_LOW_BIT]) begin
        low_voltage_flag_q <= 1'b0;
      end
      if (reference_stable_flag && !stable_prev_q) begin
        stable_evt_q <= 1'b1;
      end else if (wr_hit && avs_address == lvd_pkg::ADDR_STATUS
                   && avs_writedata[lvd_pkg::STAT_STABLE_BIT]) begin
        stable_evt_q <= 1'b0;
      end
    end
  end

  // Interrupt, wake and vector outputs, registered
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
      wake_req <= 1'b0;
      vector_req <= 1'b0;
    end else begin
      irq <= (low_voltage_flag_q && low_voltage_irq_enable)
          || (stable_evt_q && mask_q[lvd_pkg::STAT_STABLE_BIT]);
      wake_req <= sleep_q && low_voltage_flag_q && !wake_req;
      vector_req <= low_voltage_flag_q && low_voltage_irq_enable
                    && global_irq_enable_q;
    end
  end

  // Read mux; unmapped words read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (avs_address)
      lvd_pkg::ADDR_CTRL: begin
        rdata_d[lvd_pkg::CTRL_STABLE_BIT] = reference_stable_flag;
        rdata_d[lvd_pkg::CTRL_EN_BIT] = detector_power_enable;
        rdata_d[lvd_pkg::CTRL_LEVEL_MSB:0] = trip_level_code; // bits 7-6 stay zero
      end
      lvd_pkg::ADDR_STATUS: begin
        rdata_d[lvd_pkg::STAT_LOW_BIT] = low_voltage_flag_q;
        rdata_d[lvd_pkg::STAT_STABLE_BIT] = stable_evt_q;
      end
      lvd_pkg::ADDR_MASK: rdata_d[1:0] = mask_q;
      lvd_pkg::ADDR_SYS: begin
        rdata_d[lvd_pkg::SYS_GIE_BIT] = global_irq_enable_q;
        rdata_d[lvd_pkg::SYS_SLEEP_BIT] = sleep_q;
      end
      default: rdata_d = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (bus_req && avs_read && avs_waitrequest) begin
      avs_readdata <= rdata_d;
    end
  end

  // Assertions, gathered after all the logic that they guard
  // Flag may only rise from a settled, powered comparator
  property p_flag_needs_stable;
    @(posedge core_clk) disable iff (reset)
      $rose(low_voltage_flag_q) |-> $past(reference_stable_flag) && $past(detector_power_enable);
  endproperty
  a_flag_needs_stable: assert property (p_flag_needs_stable)
    else $error("low flag set without stable reference");
  // A qualified drop always lands in the flag; a clear racing it loses
  property p_drop_sets;
    @(posedge core_clk) disable iff (reset)
      drop_event |=> low_voltage_flag_q;
  endproperty
  a_drop_sets: assert property (p_drop_sets)
    else $error("drop did not set flag");
  property p_reclear_holds;
    @(posedge core_clk) disable iff (reset)
      (drop_event && wr_hit && avs_address == lvd_pkg::ADDR_STATUS) |=> low_voltage_flag_q;
  endproperty
  a_reclear_holds: assert property (p_reclear_holds)
    else $error("flag lost while condition held");
  // A clear with no drop pending does take
  property p_flag_clears;
    @(posedge core_clk) disable iff (reset)
      (wr_hit && avs_address == lvd_pkg::ADDR_STATUS
        && avs_writedata[lvd_pkg::STAT_LOW_BIT] && !drop_event) |=> !low_voltage_flag_q;
  endproperty
  a_flag_clears: assert property (p_flag_clears)
    else $error("write one did not clear low flag");
  // External select follows the code one cycle late
  property p_ext_select;
    @(posedge core_clk) disable iff (reset)
      ##1 ext_input_select == ($past(trip_level_code) == lvd_pkg::LEVEL_EXTERNAL);
  endproperty
  a_ext_select: assert property (p_ext_select)
    else $error("external select wrong");
  // Upper control bits never read back
  property p_top_bits_zero;
    @(posedge core_clk) disable iff (reset)
      avs_readdata[7:6] == 2'h0;
  endproperty
  a_top_bits_zero: assert property (p_top_bits_zero)
    else $error("reserved bits nonzero");
  // Sleep wake: one pulse, then the sleep bit drops
  sequence s_sleep_flag;
    sleep_q && low_voltage_flag_q && !wake_req;
  endsequence
  property p_wake;
    @(posedge core_clk) disable iff (reset)
      s_sleep_flag |=> wake_req ##1 !sleep_q;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake from sleep");
  property p_wake_pulse;
    @(posedge core_clk) disable iff (reset)
      wake_req |=> !wake_req;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("wake request longer than one cycle");
  // Vector only with global enable
  property p_vector_gie;
    @(posedge core_clk) disable iff (reset)
      vector_req |-> $past(global_irq_enable_q);
  endproperty
  a_vector_gie: assert property (p_vector_gie)
    else $error("vector without global enable");
  // Control write stores enable and code
  property p_en_write;
    @(posedge core_clk) disable iff (reset)
      (wr_hit && avs_address == lvd_pkg::ADDR_CTRL)
        |=> detector_power_enable == $past(avs_writedata[lvd_pkg::CTRL_EN_BIT]);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("enable bit not stored");
  property p_trip_write;
    @(posedge core_clk) disable iff (reset)
      (wr_hit && avs_address == lvd_pkg::ADDR_CTRL)
        |=> trip_level_code == $past(avs_writedata[lvd_pkg::CTRL_LEVEL_MSB:0]);
  endproperty
  a_trip_write: assert property (p_trip_write)
    else $error("trip code not stored");
  // Powered-down detector neither reports stable nor raises the flag
  property p_disabled_no_stable;
    @(posedge core_clk) disable iff (reset)
      !detector_power_enable [*8] |-> !reference_stable_flag;
  endproperty
  a_disabled_no_stable: assert property (p_disabled_no_stable)
    else $error("stable while powered down");
  property p_off_no_flag;
    @(posedge core_clk) disable iff (reset)
      !detector_power_enable |=> !$rose(low_voltage_flag_q);
  endproperty
  a_off_no_flag: assert property (p_off_no_flag)
    else $error("low flag rose while powered down");
  // Every enabling starts over with the stable flag low
  property p_restart_settles;
    @(posedge core_clk) disable iff (reset)
      $rose(detector_power_enable) |-> !reference_stable_flag ##1 !reference_stable_flag;
  endproperty
  a_restart_settles: assert property (p_restart_settles)
    else $error("stable reported right after enabling");
  property p_stable_event;
    @(posedge core_clk) disable iff (reset)
      $rose(reference_stable_flag) |=> stable_evt_q;
  endproperty
  a_stable_event: assert property (p_stable_event)
    else $error("stable rise not latched");
  // Masked status never drives the interrupt
  property p_mask_gates_irq;
    @(posedge core_clk) disable iff (reset)
      (mask_q == 2'h0) |=> !irq;
  endproperty
  a_mask_gates_irq: assert property (p_mask_gates_irq)
    else $error("interrupt with all sources masked");
  // Handshake: one wait state, one accept cycle, then busy again
  sequence s_req_waiting;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_accept_then_wait;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_one_wait;
    @(posedge core_clk) disable iff (reset)
      s_req_waiting |=> s_accept_then_wait;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("waitrequest not low for exactly one cycle");
  // Read data holds between reads
  property p_rdata_stands;
    @(posedge core_clk) disable iff (reset)
      !(bus_req && avs_read && avs_waitrequest) |=> $stable(avs_readdata);
  endproperty
  a_rdata_stands: assert property (p_rdata_stands)
    else $error("read data changed without a read");
endmodule : lvd_ctrl
`default_nettype wire

// ===== design/lvd_pkg.sv
// Package of register map, field layout, reset values and timing for the drop detector
`default_nettype none
package lvd_pkg;
  // Register word indices on the slave address bus
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_MASK = 4'h2;
  localparam logic [3:0] ADDR_SYS = 4'h3;
  // Control field positions
  localparam int CTRL_STABLE_BIT = 5;
  localparam int CTRL_EN_BIT = 4;
  localparam int CTRL_LEVEL_MSB = 3;
  // Reset values: level code 0101, detector off
  localparam logic [3:0] LEVEL_RESET = 4'h5;
  localparam logic EN_RESET = 1'b0;
  localparam logic [3:0] LEVEL_EXTERNAL = 4'hF;
  localparam logic [3:0] LEVEL_RESERVED = 4'h0;
  // Status bit positions
  localparam int STAT_LOW_BIT = 0;
  localparam int STAT_STABLE_BIT = 1;
  // System register bit positions
  localparam int SYS_GIE_BIT = 0;
  localparam int SYS_SLEEP_BIT = 1;
  // Reference settling time, counted on the free-running reference oscillator
  localparam int SETTLE_US = 20;
  localparam int REF_OSC_KHZ = 1000;
  localparam int SETTLE_TICKS = (SETTLE_US * REF_OSC_KHZ + 999) / 1000;
  localparam logic [7:0] SETTLE_TICKS_W = 8'(SETTLE_TICKS);
endpackage : lvd_pkg
`default_nettype wire

// ===== design/lvd_sync.sv
// Two flip-flop level synchroniser
`default_nettype none
module lvd_sync (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;
  // First stage read only by the second
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta_q <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : lvd_sync
`default_nettype wire

// ===== design/lvd_settle_timer.sv
// Reference settling timer clocked by the independent reference oscillator
`default_nettype none
module lvd_settle_timer (
  input wire logic ref_osc_clk,
  input wire logic ref_reset,
  input wire logic power_en,
  output logic settled
);
  logic [7:0] count_q;
  logic en_meta_q;
  logic en_q;
  // Enable brought over from the core domain
  always_ff @(posedge ref_osc_clk or posedge ref_reset) begin
    if (ref_reset) begin
      en_meta_q <= 1'b0;
      en_q <= 1'b0;
    end else begin
      en_meta_q <= power_en;
      en_q <= en_meta_q;
    end
  end
  // Fixed time, independent of core clock rate; restarts on each enable
  always_ff @(posedge ref_osc_clk or posedge ref_reset) begin
    if (ref_reset) begin
      count_q <= 8'h00;
      settled <= 1'b0;
    end else if (!en_q) begin
      count_q <= 8'h00;
      settled <= 1'b0;
    end else if (count_q == lvd_pkg::SETTLE_TICKS_W - 8'h01) begin
      settled <= 1'b1;
    end else begin
      count_q <= count_q + 8'h01;
    end
  end
endmodule : lvd_settle_timer
`default_nettype wire

// ===== bench/lvd_analog_model.sv
// Behavioural comparator, reference and reference oscillator beside the drop detector
`default_nettype none
module lvd_analog_model (
  input wire logic detector_power_enable,
  input wire logic [3:0] trip_level_code,
  input wire logic ext_input_select,
  input wire logic [3:0] supply_level,
  input wire logic ext_pin_low,
  output logic cmp_below,
  output logic ref_osc_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  // Free-running 1 MHz oscillator, unrelated in phase to the core clock
  initial ref_osc_clk = 1'b0;
  always #500 ref_osc_clk = ~ref_osc_clk;
  // Powered-down comparator gives no drop indication at all
  always_comb begin
    if (!detector_power_enable) cmp_below = 1'b0;
    else if (ext_input_select) cmp_below = ext_pin_low;
    else cmp_below = (supply_level < trip_level_code);
  end
endmodule : lvd_analog_model
`default_nettype wire

// ===== bench/low_voltage_detect_control_tb.sv
// Self-checking bench for the drop detector control block
`default_nettype none
module low_voltage_detect_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, reset = 1'b1, rd_q = 1'b0, wr_q = 1'b0, ext_low = 1'b0;
  logic [3:0] addr = 4'h0, be = 4'hF, supply = 4'hF, trip;
  logic [31:0] wdata = 32'h0, rdata;
  logic waitreq, ref_clk, below, pwr, ext_sel, irq, wake, vec, seen;
  logic [7:0] r;
  int mismatches = 0, num_checks = 0;
  time t0;
  always #5 core_clk = ~core_clk;
  lvd_ctrl i_dut (.core_clk(core_clk), .reset(reset), .ref_osc_clk(ref_clk),
    .avs_address(addr), .avs_read(rd_q), .avs_write(wr_q), .avs_writedata(wdata),
    .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(waitreq),
    .cmp_below(below), .detector_power_enable(pwr), .trip_level_code(trip),
    .ext_input_select(ext_sel), .irq(irq), .wake_req(wake), .vector_req(vec));
  lvd_analog_model i_ana (.detector_power_enable(pwr), .trip_level_code(trip),
    .ext_input_select(ext_sel), .supply_level(supply), .ext_pin_low(ext_low),
    .cmp_below(below), .ref_osc_clk(ref_clk));
  task automatic end_of_test();
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // One Avalon transfer; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    addr <= a;
    rd_q <= !w;
    wr_q <= w;
    wdata <= {24'h0, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (n >= 50) mismatches++;
    r = rdata[7:0];
    rd_q <= 1'b0;
    wr_q <= 1'b0;
  endtask : bus
  task automatic rchk(input string name, input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(name, exp, r);
  endtask : rchk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  // Reset long enough for both the core and the reference domain
  task automatic do_reset();
    reset <= 1'b1;
    cyc(5);
    repeat (2) @(posedge ref_clk);
    @(posedge core_clk);
    reset <= 1'b0;
  endtask : do_reset
  initial begin
    #300us;
    mismatches++;
    end_of_test();
  end
  initial begin
    do_reset();
    rchk("ctrl_reset", lvd_pkg::ADDR_CTRL, 8'h05);
    rchk("status_reset", lvd_pkg::ADDR_STATUS, 8'h00);
    chk("power_reset", 8'h00, {7'h0, pwr});
    // Setup order: code first with power off, then power
    bus(1'b1, lvd_pkg::ADDR_CTRL, 8'hC3);
    rchk("ctrl_upper_zero", lvd_pkg::ADDR_CTRL, 8'h03);
    bus(1'b1, lvd_pkg::ADDR_CTRL, 8'hF3);
    t0 = $time;
    supply <= 4'h1;
    rchk("ctrl_not_stable", lvd_pkg::ADDR_CTRL, 8'h13);
    chk("power_on", 8'h01, {7'h0, pwr});
    chk("trip_out", 8'h03, {4'h0, trip});
    cyc(20);
    rchk("flag_held_unstable", lvd_pkg::ADDR_STATUS, 8'h00);
    supply <= 4'hF;
    r = 8'h00;
    for (int i = 0; i < 1000 && r[5] !== 1'b1; i++) bus(1'b0, lvd_pkg::ADDR_CTRL, 8'h00);
    chk("ctrl_stable", 8'h33, r);
    chk("settle_time", 8'h01, {7'h0, ($time - t0 >= 20us && $time - t0 < 24us)});
    rchk("stable_event", lvd_pkg::ADDR_STATUS, 8'h02);
    bus(1'b1, lvd_pkg::ADDR_STATUS, 8'h03);
    rchk("status_clear", lvd_pkg::ADDR_STATUS, 8'h00);
    bus(1'b1, lvd_pkg::ADDR_MASK, 8'h01);
    bus(1'b1, lvd_pkg::ADDR_SYS, 8'h01);
    supply <= 4'h1;
    cyc(8);
    rchk("flag_set", lvd_pkg::ADDR_STATUS, 8'h01);
    chk("irq_vec", 8'h03, {6'h0, irq, vec});
    bus(1'b1, lvd_pkg::ADDR_STATUS, 8'h01);
    cyc(4);
    rchk("flag_sticks", lvd_pkg::ADDR_STATUS, 8'h01);
    bus(1'b1, lvd_pkg::ADDR_MASK, 8'h00);
    cyc(2);
    chk("irq_masked", 8'h00, {7'h0, irq});
    // Byte lane off and unmapped place must both leave state alone
    be <= 4'h0;
    bus(1'b1, lvd_pkg::ADDR_MASK, 8'h03);
    be <= 4'hF;
    rchk("mask_be_off", lvd_pkg::ADDR_MASK, 8'h00);
    bus(1'b1, 4'h7, 8'hFF);
    rchk("unmapped", 4'h7, 8'h00);
    // Sleep with global enable off: wake but no vector; flag cleared before sleeping
    supply <= 4'hF;
    bus(1'b1, lvd_pkg::ADDR_MASK, 8'h01);
    cyc(4);
    bus(1'b1, lvd_pkg::ADDR_STATUS, 8'h03);
    rchk("status_idle", lvd_pkg::ADDR_STATUS, 8'h00);
    bus(1'b1, lvd_pkg::ADDR_SYS, 8'h02);
    seen = 1'b0;
    supply <= 4'h1;
    repeat (20) begin
      @(posedge core_clk);
      if (wake === 1'b1) seen = 1'b1;
    end
    chk("wake", 8'h01, {7'h0, seen});
    chk("no_vector", 8'h00, {7'h0, vec});
    rchk("sleep_left", lvd_pkg::ADDR_SYS, 8'h00);
    // External pin selected by the all-ones code
    supply <= 4'hF;
    bus(1'b1, lvd_pkg::ADDR_CTRL, 8'h1F);
    cyc(4);
    bus(1'b1, lvd_pkg::ADDR_STATUS, 8'h03);
    chk("ext_select", 8'h01, {7'h0, ext_sel});
    ext_low <= 1'b1;
    cyc(8);
    rchk("ext_flag", lvd_pkg::ADDR_STATUS, 8'h01);
    ext_low <= 1'b0;
    bus(1'b1, lvd_pkg::ADDR_CTRL, 8'h03);
    cyc(4);
    rchk("ctrl_off", lvd_pkg::ADDR_CTRL, 8'h03);
    chk("power_off", 8'h00, {7'h0, pwr});
    bus(1'b1, lvd_pkg::ADDR_CTRL, 8'h1A);
    do_reset();
    rchk("ctrl_rereset", lvd_pkg::ADDR_CTRL, 8'h05);
    chk("power_rereset", 8'h00, {7'h0, pwr});
    end_of_test();
  end
endmodule : low_voltage_detect_control_tb
`default_nettype wire
